// File: core/usbi_core.sv
// usb interface module: event flags, flag ports, packet capture and phy control
`timescale 1ns/1ps
`default_nettype none
module usbi_core (
	input wire logic sys_clk, // system clock, 125 MHz
	input wire logic arst_n, // async reset, active low
	input wire usbi_pkg::usbi_reg_req_t reg_req, // register access request
	output logic [31:0] reg_rdata, // read data
	output logic reg_rd_valid, // read data valid pulse
	input wire logic receive_active_input, // transceiver receive active
	input wire logic receive_error_input, // transceiver receive error
	input wire logic token_ok, // token decoded pulse
	input wire logic crc16_fail, // data packet crc16 failure pulse
	input wire logic pid_strobe, // packet identifier received
	input wire logic [3:0] pid_value, // received packet identifier
	input wire logic ep_strobe, // endpoint received
	input wire logic [3:0] ep_value, // received endpoint number
	input wire logic sof_strobe, // start-of-frame received
	input wire logic [10:0] sof_value, // received frame number
	input wire logic suspend_enter, // request to enter suspend
	input wire logic resume_request, // software resume request
	input wire logic [1:0] linestate_pin, // raw line state pins
	output logic flag_output_port_a, // flag port from mask 6:0
	output logic flag_output_port_b, // flag port from mask 14:8
	output logic flag_output_port_c, // flag port from mask 22:16
	output logic flag_output_port_d, // flag port from mask 30:24
	output logic [4:0] rx_endpoint_out, // endpoint on receive port
	output logic rx_endpoint_strobe, // receive port valid pulse
	output logic transceiver_data_port_low_pd_dis, // pulldown disable, low port
	output logic transceiver_data_port_high_pd_dis, // pulldown disable, high port
	output logic [2:0] transceiver_config_pins, // transceiver config pins
	output logic [1:0] linestate_filt, // filtered line state
	output logic phy_suspend_n // transceiver suspend, active low
);
	import usbi_pkg::*;

	function automatic logic hit(input usbi_reg_req_t req, input logic [7:0] off);
		hit = (req.addr == off);
	endfunction : hit

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [NUM_FLAGS-1:0] flags, next_flags, sticky, next_sticky, flag_src, flag_clr;
	logic [31:0] masks, next_masks, otg_mask, next_otg_mask;
	logic [FRAME_W-1:0] frame_counter, next_frame_counter;
	logic [PID_W-1:0] last_pid, next_last_pid;
	logic [EP_W-1:0] last_ep, next_last_ep;
	logic last_ep_valid, next_last_ep_valid;
	logic [NUM_EP-1:0] ep_marking, next_ep_marking;
	logic [POWER_W-1:0] power_data, next_power_data;
	logic pd_dis, next_pd_dis, cause_se0, next_cause_se0, cause_k, next_cause_k;
	logic [3:0] filt_log2, next_filt_log2;
	logic auto_resume, next_auto_resume;
	logic [2:0] conf, next_conf;
	usbi_susp_t susp, next_susp;
	logic next_suspend_n;
	logic [NUM_PORTS-1:0] ports, next_ports;
	logic [4:0] next_rx_ep;
	logic [31:0] next_rdata;
	logic wr, rd;

	assign wr = reg_req.wr;
	assign rd = reg_req.rd;

	usbi_linestate_filter u_filter (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.linestate_pin(linestate_pin),
		.filt_log2(filt_log2),
		.linestate_filt(linestate_filt)
	);

	////////////////////////////////////////////////////////////////////////////
	// flag sources and flag ports
	always_comb begin
		flag_src = '0;
		flag_src[FLAG_TOKEN_OK] = token_ok;
		flag_src[FLAG_SE0] = (linestate_filt == LS_SE0);
		flag_src[FLAG_K] = (linestate_filt == LS_K);
		flag_src[FLAG_J] = (linestate_filt == LS_J);
		flag_src[FLAG_CRC16] = crc16_fail;
		flag_src[FLAG_RX_ACTIVE] = receive_active_input;
		flag_src[FLAG_RX_ERROR] = receive_error_input;
		flag_clr = (wr && hit(reg_req, OFF_EVENT_FLAGS)) ? reg_req.wdata[NUM_FLAGS-1:0] : '0;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
			// set wins over a clear in the same cycle
			assign next_flags[gi] = sticky[gi] ? ((flags[gi] & ~flag_clr[gi]) | flag_src[gi])
				: flag_src[gi];
		end
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			assign next_ports[gi] = |(flags & masks[gi*MASK_STRIDE +: NUM_FLAGS]);
		end
	endgenerate

	assign flag_output_port_a = ports[0];
	assign flag_output_port_b = ports[1];
	assign flag_output_port_c = ports[2];
	assign flag_output_port_d = ports[3];

	////////////////////////////////////////////////////////////////////////////
	// register writes, packet capture and suspend control
	always_comb begin
		next_sticky = sticky;
		next_masks = masks;
		next_frame_counter = frame_counter;
		next_ep_marking = ep_marking;
		next_otg_mask = otg_mask;
		next_power_data = power_data;
		next_pd_dis = pd_dis;
		next_cause_se0 = cause_se0;
		next_cause_k = cause_k;
		next_filt_log2 = filt_log2;
		next_auto_resume = auto_resume;
		next_conf = conf;
		next_last_pid = last_pid;
		next_last_ep = last_ep;
		next_last_ep_valid = last_ep_valid;
		next_susp = susp;
		next_rx_ep = rx_endpoint_out;
		if (wr) begin
			if (hit(reg_req, OFF_STICKY)) next_sticky = reg_req.wdata[NUM_FLAGS-1:0];
			if (hit(reg_req, OFF_PORT_MASKS)) next_masks = reg_req.wdata;
			if (hit(reg_req, OFF_FRAME_COUNTER)) begin
				next_frame_counter = reg_req.wdata[FRAME_W-1:0];
			end
			if (hit(reg_req, OFF_ENDPOINT_MARKING)) next_ep_marking = reg_req.wdata[NUM_EP-1:0];
			if (hit(reg_req, OFF_OTG_FLAG_MASK)) next_otg_mask = reg_req.wdata;
			if (hit(reg_req, OFF_POWER_SIGNAL)) begin
				next_power_data = reg_req.wdata[POWER_W-1:0];
			end
			if (hit(reg_req, OFF_TRANSCEIVER_CTRL)) begin
				next_pd_dis = reg_req.wdata[CTRL_PD_DISABLE];
				next_cause_se0 = reg_req.wdata[CTRL_CAUSE_SE0];
				next_cause_k = reg_req.wdata[CTRL_CAUSE_K];
				next_filt_log2 = reg_req.wdata[CTRL_FILT_LSB +: 4];
				next_auto_resume = reg_req.wdata[CTRL_AUTO_RESUME];
				next_conf = reg_req.wdata[CTRL_CONF_LSB +: 3];
			end
		end
		// received frame number overrides a write in the same cycle
		if (sof_strobe) next_frame_counter = sof_value;
		if (pid_strobe) next_last_pid = pid_value;
		if (ep_strobe) begin
			next_last_ep = ep_value;
			next_last_ep_valid = 1'b1;
			next_rx_ep = {1'b0, ep_value} | (ep_marking[ep_value] ? EP_MARK_OR : 5'h00);
		end
		case (susp)
			SUSP_AWAKE: begin
				if (suspend_enter) next_susp = SUSP_ASLEEP;
			end
			SUSP_ASLEEP: begin
				if (auto_resume && linestate_filt == LS_SE0) begin
					next_cause_se0 = 1'b1;
					next_susp = SUSP_AWAKE;
				end else if (auto_resume && linestate_filt == LS_K) begin
					next_cause_k = 1'b1;
					next_susp = SUSP_AWAKE;
				end else if (resume_request) begin
					next_susp = SUSP_AWAKE;
				end
			end
			default: next_susp = SUSP_AWAKE;
		endcase
		next_suspend_n = (next_susp == SUSP_AWAKE);
	end

	////////////////////////////////////////////////////////////////////////////
	// read path
	always_comb begin
		next_rdata = RESET_ZERO;
		case (reg_req.addr)
			OFF_EVENT_FLAGS: next_rdata[NUM_FLAGS-1:0] = flags;
			OFF_STICKY: next_rdata[NUM_FLAGS-1:0] = sticky;
			OFF_PORT_MASKS: next_rdata = masks;
			OFF_FRAME_COUNTER: next_rdata[FRAME_W-1:0] = frame_counter;
			OFF_LAST_PID: next_rdata[PID_W-1:0] = last_pid;
			OFF_LAST_ENDPOINT: next_rdata[EP_VALID_BIT:0] = {last_ep_valid, last_ep};
			OFF_ENDPOINT_MARKING: next_rdata[NUM_EP-1:0] = ep_marking;
			OFF_OTG_FLAG_MASK: next_rdata = otg_mask;
			OFF_POWER_SIGNAL: next_rdata[POWER_W-1:0] = power_data;
			OFF_TRANSCEIVER_CTRL: begin
				next_rdata[CTRL_PD_DISABLE] = pd_dis;
				next_rdata[CTRL_CAUSE_SE0] = cause_se0;
				next_rdata[CTRL_CAUSE_K] = cause_k;
				next_rdata[CTRL_FILT_LSB +: 4] = filt_log2;
				next_rdata[CTRL_AUTO_RESUME] = auto_resume;
				next_rdata[CTRL_CONF_LSB +: 3] = conf;
			end
			default: next_rdata = RESET_ZERO;
		endcase
		if (!rd) next_rdata = reg_rdata;
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags <= '0;
			sticky <= '0;
			masks <= RESET_ZERO;
			frame_counter <= '0;
			last_pid <= '0;
			last_ep <= '0;
			last_ep_valid <= 1'b0;
			ep_marking <= '0;
			otg_mask <= RESET_ZERO;
			power_data <= '0;
			pd_dis <= 1'b0;
			cause_se0 <= 1'b0;
			cause_k <= 1'b0;
			filt_log2 <= 4'h0;
			auto_resume <= 1'b0;
			conf <= 3'h0;
			susp <= SUSP_AWAKE;
			phy_suspend_n <= 1'b1;
			ports <= '0;
			rx_endpoint_out <= 5'h00;
			rx_endpoint_strobe <= 1'b0;
			reg_rdata <= RESET_ZERO;
			reg_rd_valid <= 1'b0;
		end else begin
			flags <= next_flags;
			sticky <= next_sticky;
			masks <= next_masks;
			frame_counter <= next_frame_counter;
			last_pid <= next_last_pid;
			last_ep <= next_last_ep;
			last_ep_valid <= next_last_ep_valid;
			ep_marking <= next_ep_marking;
			otg_mask <= next_otg_mask;
			power_data <= next_power_data;
			pd_dis <= next_pd_dis;
			cause_se0 <= next_cause_se0;
			cause_k <= next_cause_k;
			filt_log2 <= next_filt_log2;
			auto_resume <= next_auto_resume;
			conf <= next_conf;
			susp <= next_susp;
			phy_suspend_n <= next_suspend_n;
			ports <= next_ports;
			rx_endpoint_out <= next_rx_ep;
			rx_endpoint_strobe <= ep_strobe;
			reg_rdata <= next_rdata;
			reg_rd_valid <= rd;
		end
	end

	assign transceiver_data_port_low_pd_dis = pd_dis;
	assign transceiver_data_port_high_pd_dis = pd_dis;
	assign transceiver_config_pins = conf;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	property p_sticky_hold;
		(sticky[FLAG_TOKEN_OK] && flags[FLAG_TOKEN_OK] && !(wr && hit(reg_req, OFF_EVENT_FLAGS)))
			|=> flags[FLAG_TOKEN_OK];
	endproperty
	a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

	property p_track;
		!sticky[FLAG_RX_ACTIVE] |=> flags[FLAG_RX_ACTIVE] == $past(receive_active_input);
	endproperty
	a_track: assert property (p_track) else $error("flag not tracking source");

	property p_port_a;
		flag_output_port_a == |($past(flags) & $past(masks[NUM_FLAGS-1:0]));
	endproperty
	a_port_a: assert property (p_port_a) else $error("flag port a wrong");

	property p_sof;
		sof_strobe |=> frame_counter == $past(sof_value);
	endproperty
	a_sof: assert property (p_sof) else $error("frame counter not loaded");

	property p_pid;
		pid_strobe ##1 !pid_strobe |-> last_pid == $past(pid_value);
	endproperty
	a_pid: assert property (p_pid) else $error("pid not captured");

	property p_ep;
		ep_strobe |=> last_ep_valid && last_ep == $past(ep_value);
	endproperty
	a_ep: assert property (p_ep) else $error("endpoint not captured");

	property p_mark;
		ep_strobe |=> rx_endpoint_strobe && rx_endpoint_out[4] == $past(ep_marking[ep_value])
			&& rx_endpoint_out[3:0] == $past(ep_value);
	endproperty
	a_mark: assert property (p_mark) else $error("receive port endpoint wrong");

	property p_pd;
		(wr && hit(reg_req, OFF_TRANSCEIVER_CTRL)) |=>
			transceiver_data_port_high_pd_dis == $past(reg_req.wdata[CTRL_PD_DISABLE]);
	endproperty
	a_pd: assert property (p_pd) else $error("pulldown disable wrong");

	property p_se0;
		(susp == SUSP_ASLEEP && auto_resume && linestate_filt == LS_SE0)
			|=> cause_se0 && phy_suspend_n;
	endproperty
	a_se0: assert property (p_se0) else $error("se0 resume not flagged");

	property p_k;
		(susp == SUSP_ASLEEP && auto_resume && linestate_filt == LS_K)
			|=> cause_k && (cause_se0 == $past(cause_se0));
	endproperty
	a_k: assert property (p_k) else $error("k resume not flagged");

	property p_no_auto;
		(susp == SUSP_ASLEEP && !auto_resume && !resume_request) |=> !phy_suspend_n;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("resumed without auto enable");

	property p_reserved;
		$past(rd) && $past(reg_req.addr) == OFF_STICKY |-> reg_rdata[31:7] == 25'h0000000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	c_sticky_clear: cover property (flags[FLAG_TOKEN_OK] && sticky[FLAG_TOKEN_OK] ##1 !flags[FLAG_TOKEN_OK]);
	c_auto_se0: cover property (susp == SUSP_ASLEEP ##1 cause_se0 && susp == SUSP_AWAKE);
	c_marked_ep: cover property (rx_endpoint_strobe && rx_endpoint_out[4]);

endmodule : usbi_core
`default_nettype wire

// File: core/usbi_linestate_filter.sv
// line-state synchroniser and programmable stability filter
`timescale 1ns/1ps
`default_nettype none
module usbi_linestate_filter (
	input wire logic sys_clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic [1:0] linestate_pin, // raw line state from transceiver
	input wire logic [3:0] filt_log2, // log2 of stability delay
	output logic [1:0] linestate_filt // filtered line state
);
	import usbi_pkg::*;

	logic [1:0] sync1, sync2, sync3;
	logic [1:0] pend, next_pend, next_filt;
	logic [FILT_CNT_W-1:0] cnt, next_cnt, limit;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		limit = (16'h0001 << filt_log2) - 16'h0001;
		next_pend = pend;
		next_filt = linestate_filt;
		next_cnt = '0;
		if (sync2 != sync3) begin
			next_cnt = '0;
		end else if (sync3 != pend) begin
			next_pend = sync3;
		end else if (pend != linestate_filt) begin
			if (cnt == limit) begin
				next_filt = pend;
			end else begin
				next_cnt = cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= LS_SE0;
			sync2 <= LS_SE0;
			sync3 <= LS_SE0;
			pend <= LS_SE0;
			linestate_filt <= LS_SE0;
			cnt <= '0;
		end else begin
			sync1 <= linestate_pin;
			sync2 <= sync1;
			sync3 <= sync2;
			pend <= next_pend;
			linestate_filt <= next_filt;
			cnt <= next_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	property p_filt_delay;
		@(posedge sys_clk) disable iff (!arst_n)
		(linestate_filt != $past(linestate_filt)) |-> ($past(cnt) == $past(limit));
	endproperty
	a_filt_delay: assert property (p_filt_delay) else $error("line state passed early");

	property p_filt_zero;
		@(posedge sys_clk) disable iff (!arst_n)
		(filt_log2 == 4'h0 && sync2 == sync3 && sync3 == pend && pend != linestate_filt)
			|=> (linestate_filt == $past(pend));
	endproperty
	a_filt_zero: assert property (p_filt_zero) else $error("unfiltered change not passed");

endmodule : usbi_linestate_filter
`default_nettype wire

// File: core/usbi_pkg.sv
// package: register map, field layout and constants of the usb interface module
package usbi_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h1C;
	localparam logic [7:0] OFF_STICKY = 8'h20;
	localparam logic [7:0] OFF_PORT_MASKS = 8'h24;
	localparam logic [7:0] OFF_FRAME_COUNTER = 8'h28;
	localparam logic [7:0] OFF_LAST_PID = 8'h2C;
	localparam logic [7:0] OFF_LAST_ENDPOINT = 8'h30;
	localparam logic [7:0] OFF_ENDPOINT_MARKING = 8'h34;
	localparam logic [7:0] OFF_OTG_FLAG_MASK = 8'h38;
	localparam logic [7:0] OFF_POWER_SIGNAL = 8'h3C;
	localparam logic [7:0] OFF_TRANSCEIVER_CTRL = 8'h40;

	// widths
	localparam int NUM_FLAGS = 7;
	localparam int NUM_PORTS = 4;
	localparam int MASK_STRIDE = 8;
	localparam int FRAME_W = 11;
	localparam int PID_W = 4;
	localparam int EP_W = 4;
	localparam int NUM_EP = 16;
	localparam int POWER_W = 9;
	localparam int FILT_CNT_W = 16;

	// event flag positions
	localparam int FLAG_TOKEN_OK = 6;
	localparam int FLAG_SE0 = 5;
	localparam int FLAG_K = 4;
	localparam int FLAG_J = 3;
	localparam int FLAG_CRC16 = 2;
	localparam int FLAG_RX_ACTIVE = 1;
	localparam int FLAG_RX_ERROR = 0;

	// endpoint register fields
	localparam int EP_VALID_BIT = 4;
	localparam logic [4:0] EP_MARK_OR = 5'h10;

	// transceiver control fields
	localparam int CTRL_PD_DISABLE = 18;
	localparam int CTRL_CAUSE_SE0 = 13;
	localparam int CTRL_CAUSE_K = 12;
	localparam int CTRL_FILT_LSB = 8;
	localparam int CTRL_AUTO_RESUME = 7;
	localparam int CTRL_CONF_LSB = 4;

	// reset values
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;

	// line states
	localparam logic [1:0] LS_SE0 = 2'h0;
	localparam logic [1:0] LS_J = 2'h1;
	localparam logic [1:0] LS_K = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [31:0] wdata;
	} usbi_reg_req_t;

	typedef enum logic {
		SUSP_AWAKE,
		SUSP_ASLEEP
	} usbi_susp_t;

endpackage : usbi_pkg

// File: tb/usbi_core_bench.sv
// self-checking bench for the usb interface module core
`timescale 1ns/1ps
`default_nettype none
module usbi_core_bench;
	import usbi_pkg::*;
	logic sys_clk;
	logic arst_n;
	usbi_reg_req_t reg_req;
	logic [31:0] reg_rdata;
	logic reg_rd_valid;
	logic token_ok, crc16_fail, pid_strobe, ep_strobe, sof_strobe;
	logic [3:0] pid_value, ep_value;
	logic [10:0] sof_value;
	logic suspend_enter, resume_request;
	logic [1:0] linestate_pin, linestate_filt;
	logic rx_act, rx_err, port_a, port_b, port_c, port_d;
	logic [4:0] rx_endpoint_out;
	logic rx_endpoint_strobe, pd_lo, pd_hi, phy_suspend_n;
	logic [2:0] conf_pins;
	int n_errors = 0;
	int n_checks = 0;

	usbi_core uut (.sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
		.receive_active_input(rx_act), .receive_error_input(rx_err),
		.token_ok(token_ok), .crc16_fail(crc16_fail), .pid_strobe(pid_strobe),
		.pid_value(pid_value), .ep_strobe(ep_strobe), .ep_value(ep_value),
		.sof_strobe(sof_strobe), .sof_value(sof_value), .suspend_enter(suspend_enter),
		.resume_request(resume_request), .linestate_pin(linestate_pin),
		.flag_output_port_a(port_a), .flag_output_port_b(port_b),
		.flag_output_port_c(port_c), .flag_output_port_d(port_d),
		.rx_endpoint_out(rx_endpoint_out), .rx_endpoint_strobe(rx_endpoint_strobe),
		.transceiver_data_port_low_pd_dis(pd_lo), .transceiver_data_port_high_pd_dis(pd_hi),
		.transceiver_config_pins(conf_pins), .linestate_filt(linestate_filt),
		.phy_suspend_n(phy_suspend_n));
	usbi_phy_model phy (.sys_clk(sys_clk), .linestate_pin(linestate_pin),
		.receive_active_input(rx_act), .receive_error_input(rx_err));

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : tick
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : check_word
	task automatic check_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask : check_bit
	// whole 32-bit accesses; strobe dropped a cycle before the next request
	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		reg_req.wr = 1'b1;
		reg_req.addr = addr;
		reg_req.wdata = data;
		tick(1);
		reg_req.wr = 1'b0;
		tick(1);
	endtask : reg_write
	task automatic expect_reg(input logic [7:0] addr, input logic [31:0] exp);
		reg_req.rd = 1'b1;
		reg_req.addr = addr;
		tick(1);
		reg_req.rd = 1'b0;
		check_bit(reg_rd_valid, 1'b1, "read valid");
		check_word(reg_rdata, exp, "register read");
		tick(1);
	endtask : expect_reg
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] offs [9];
		logic [31:0] full [9];
		offs = '{8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h44};
		full = '{32'h7F, 32'hFFFF_FFFF, 32'h7FF, 0, 0, 32'hFFFF, 32'hFFFF_FFFF, 32'h1FF, 0};
		for (int i = 0; i < 9; i++) begin
			expect_reg(offs[i], RESET_ZERO);
			reg_write(offs[i], 32'hFFFF_FFFF);
			expect_reg(offs[i], full[i]);
			reg_write(offs[i], 32'h0);
		end
		$display("register map test done");
	endtask : t_regs
	task automatic t_flags;
		reg_write(OFF_STICKY, 32'h41);
		phy.set_rx(1'b1, 1'b1);
		token_ok = 1'b1;
		tick(1);
		phy.set_rx(1'b0, 1'b0);
		token_ok = 1'b0;
		tick(3);
		expect_reg(OFF_EVENT_FLAGS, 32'h49);
		reg_write(OFF_EVENT_FLAGS, 32'h7F);
		expect_reg(OFF_EVENT_FLAGS, 32'h08);
		reg_write(OFF_STICKY, 32'h0);
		phy.set_rx(1'b0, 1'b1);
		tick(1);
		phy.set_rx(1'b0, 1'b0);
		tick(3);
		expect_reg(OFF_EVENT_FLAGS, 32'h08);
		$display("flag test done");
	endtask : t_flags
	task automatic t_ports;
		reg_write(OFF_PORT_MASKS, 32'h0810_0402);
		phy.set_rx(1'b1, 1'b0);
		crc16_fail = 1'b1;
		tick(3);
		check_word({port_a, port_b, port_c, port_d}, 4'b1101, "ports on");
		phy.set_rx(1'b0, 1'b0);
		crc16_fail = 1'b0;
		tick(3);
		check_word({port_a, port_b, port_c, port_d}, 4'b0001, "ports off");
		reg_write(OFF_PORT_MASKS, 32'h0);
		$display("flag port test done");
	endtask : t_ports
	task automatic send_ep(input logic [3:0] ep, input logic [4:0] exp);
		ep_strobe = 1'b1;
		ep_value = ep;
		tick(1);
		ep_strobe = 1'b0;
		check_bit(rx_endpoint_strobe, 1'b1, "endpoint strobe");
		check_word(rx_endpoint_out, exp, "rx endpoint");
		tick(1);
		check_bit(rx_endpoint_strobe, 1'b0, "endpoint strobe end");
		expect_reg(OFF_LAST_ENDPOINT, {27'h0, 1'b1, ep});
	endtask : send_ep
	task automatic t_capture;
		sof_strobe = 1'b1;
		sof_value = 11'h5A3;
		pid_strobe = 1'b1;
		pid_value = 4'hD;
		tick(1);
		sof_strobe = 1'b0;
		pid_strobe = 1'b0;
		expect_reg(OFF_FRAME_COUNTER, 32'h5A3);
		expect_reg(OFF_LAST_PID, 32'hD);
		reg_write(OFF_ENDPOINT_MARKING, 32'h8008);
		send_ep(4'h3, 5'h13);
		send_ep(4'h5, 5'h05);
		send_ep(4'hF, 5'h1F);
		reg_write(OFF_ENDPOINT_MARKING, 32'h0);
		$display("capture test done");
	endtask : t_capture
	task automatic t_ctrl;
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h0004_0050);
		check_word({pd_lo, pd_hi, conf_pins}, 5'b11101, "phy pins");
		expect_reg(OFF_TRANSCEIVER_CTRL, 32'h0004_0050);
		reg_write(OFF_TRANSCEIVER_CTRL, 32'hFFFF_FFFF);
		expect_reg(OFF_TRANSCEIVER_CTRL, 32'h0004_3FF0);
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h0);
		check_word({pd_lo, pd_hi, conf_pins}, 5'b00000, "phy pins off");
		$display("control test done");
	endtask : t_ctrl
	task automatic t_filter;
		int cnt;
		logic held;
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h300);
		phy.set_line(LS_K);
		tick(4);
		phy.set_line(LS_J);
		held = 1'b1;
		for (int i = 0; i < 20; i++) begin
			tick(1);
			if (linestate_filt !== LS_J) held = 1'b0;
		end
		check_bit(held, 1'b1, "glitch filtered");
		phy.set_line(LS_K);
		for (cnt = 0; cnt < 40 && linestate_filt !== LS_K; cnt++) tick(1);
		check_bit(cnt >= 8 && cnt <= 14, 1'b1, "filter delay");
		phy.set_line(LS_J);
		tick(20);
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h0);
		$display("filter test done");
	endtask : t_filter
	task automatic sleep_wake(input logic [1:0] ls, input logic [31:0] exp);
		int cnt;
		suspend_enter = 1'b1;
		tick(1);
		suspend_enter = 1'b0;
		check_bit(phy_suspend_n, 1'b0, "asleep");
		phy.set_line(ls);
		for (cnt = 0; cnt < 20 && phy_suspend_n !== 1'b1; cnt++) tick(1);
		check_bit(phy_suspend_n, exp[7], "auto wake");
		expect_reg(OFF_TRANSCEIVER_CTRL, exp);
		reg_write(OFF_TRANSCEIVER_CTRL, {24'h0, exp[7:0]});
		expect_reg(OFF_TRANSCEIVER_CTRL, {24'h0, exp[7:0]});
		resume_request = 1'b1;
		tick(1);
		resume_request = 1'b0;
		check_bit(phy_suspend_n, 1'b1, "awake");
		phy.set_line(LS_J);
		tick(10);
	endtask : sleep_wake
	task automatic t_suspend;
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h80);
		sleep_wake(LS_K, 32'h1080);
		sleep_wake(LS_SE0, 32'h2080);
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h0);
		sleep_wake(LS_K, 32'h0);
		$display("suspend test done");
	endtask : t_suspend
	// mid-run reset: written fields fall back, first read right at release
	task automatic t_reset;
		reg_write(OFF_PORT_MASKS, 32'h0000_0008);
		reg_write(OFF_TRANSCEIVER_CTRL, 32'h0004_0080);
		check_word({pd_lo, pd_hi, phy_suspend_n, port_a}, 4'b1111, "before reset");
		arst_n = 1'b0;
		tick(2);
		check_word({pd_lo, pd_hi, phy_suspend_n, port_a}, 4'b0010, "in reset");
		arst_n = 1'b1;
		expect_reg(OFF_PORT_MASKS, RESET_ZERO);
		expect_reg(OFF_TRANSCEIVER_CTRL, RESET_ZERO);
		$display("reset test done");
	endtask : t_reset

	////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		n_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		wrap_up();
	end
	initial begin
		arst_n = 1'b0;
		reg_req = '0;
		{token_ok, crc16_fail, pid_strobe, ep_strobe, sof_strobe} = '0;
		{pid_value, ep_value, sof_value} = '0;
		{suspend_enter, resume_request} = '0;
		tick(6);
		arst_n = 1'b1;
		tick(10);
		t_regs();
		t_flags();
		t_ports();
		t_capture();
		t_ctrl();
		t_filter();
		t_suspend();
		t_reset();
		wrap_up();
	end
endmodule : usbi_core_bench
`default_nettype wire

// File: tb/usbi_phy_model.sv
// transceiver-side model: line state and receive status toward the core
`timescale 1ns/1ps
`default_nettype none
module usbi_phy_model (
	input wire logic sys_clk, // system clock
	output logic [1:0] linestate_pin, // line state toward the core
	output logic receive_active_input, // receive active
	output logic receive_error_input // receive error
);
	import usbi_pkg::*;
	// idle bus rests in J at full speed
	initial begin
		linestate_pin = LS_J;
		receive_active_input = 1'b0;
		receive_error_input = 1'b0;
	end
	// callers change these just after a falling edge
	task automatic set_line(input logic [1:0] ls);
		linestate_pin = ls;
	endtask : set_line
	task automatic set_rx(input logic act, input logic err);
		receive_active_input = act;
		receive_error_input = err;
	endtask : set_rx
endmodule : usbi_phy_model
`default_nettype wire
